// ---- src/usb_bulk_pkg.sv ----
/*
  package for the usb bulk transfer management block: register map, control
  field positions, header layout, carrier structs.
  assumes an axi4-lite master with 32-bit data and 17-bit byte addresses.
*/
package usb_bulk_pkg;

  localparam int ADDR_W = 17;

  // register indices: one word each, byte address is four times the index
  localparam logic [ADDR_W-3:0] CTRL_INDEX   = 15'h7F57;
  localparam logic [ADDR_W-3:0] STATUS_INDEX = 15'h7F58;
  localparam logic [ADDR_W-3:0] MASK_INDEX   = 15'h7F59;
  localparam logic [ADDR_W-3:0] FRAME_INDEX  = 15'h7F56;

  // register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = {CTRL_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = {STATUS_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] MASK_OFFSET   = {MASK_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] FRAME_OFFSET  = {FRAME_INDEX, 2'b00};

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h0F;

  // control field positions
  localparam int BIT_ACCEPT_BAD_CRC = 3;
  localparam int BIT_NAK_ALL        = 2;
  localparam int BIT_MANUAL_ZLP     = 1;
  localparam int BIT_MANUAL_RELEASE = 0;

  // event bit positions in status and mask
  localparam int EV_RX_DONE  = 0;
  localparam int EV_RX_DROP  = 1;
  localparam int EV_ZLP_SENT = 2;
  localparam int EV_PAGE_REL = 3;
  localparam int EV_W        = 4;

  localparam int BULK_MAX_LEN = 64;
  localparam int HDR_BYTES    = 6;
  localparam logic [2:0] HDR_FIRST = 3'h0;
  localparam logic [2:0] HDR_LAST  = 3'h5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // received packet as the serial engine reports it
  typedef struct packed {
    logic [3:0] endpoint;
    logic [3:0] token_code;
    logic [6:0] func_addr;
    logic       crc_bad;
  } rx_info_t;

  // header byte write to packet buffer
  typedef struct packed {
    logic [2:0] offset;
    logic [7:0] data;
  } hdr_byte_t;

endpackage

// ---- src/rx_header_writer.sv ----
/*
  serialises the six-byte receive status header into the packet buffer,
  one byte per cycle at offsets 0 through 5.
  assumes the buffer write port takes one byte per cycle without stall.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_header_writer
  import usb_bulk_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire logic      start,
  input  wire logic [47:0] header,
  output logic           busy,
  output logic           hdr_valid,
  output hdr_byte_t      hdr_byte
);

  logic [2:0]  idx_reg;
  logic [47:0] hdr_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy      <= 1'b0;
      idx_reg   <= HDR_FIRST;
      hdr_reg   <= '0;
      hdr_valid <= 1'b0;
      hdr_byte  <= '0;
    end else if (start && !busy) begin
      busy      <= 1'b1;
      idx_reg   <= HDR_FIRST;
      hdr_reg   <= header;
      hdr_valid <= 1'b0;
    end else if (busy) begin
      hdr_valid       <= 1'b1;
      hdr_byte.offset <= idx_reg;
      hdr_byte.data   <= hdr_reg[idx_reg*8 +: 8];
      idx_reg         <= idx_reg + 3'h1;
      if (idx_reg == HDR_LAST) begin
        busy <= 1'b0;
      end
    end else begin
      hdr_valid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- src/usb_bulk_transfer_management.sv ----
/*
  usb bulk transfer management: control register, receive acceptance and
  nak policy, status header build, zero-length packet and page release.
  assumes the serial engine reports packets as one-cycle pulses and that
  firmware reaches the registers over axi4-lite.
*/
// Functional notes
// - bits 7:4 of the transfer control register always read as zero.
// - the control bits reset to zero, selecting normal operation.
// - bit 3 set accepts bulk packets with bad crc; clear refuses them.
// - bit 2 set answers every received data packet with nak.
// - while nak-all is set no page request goes to the page dma.
// - with bit 1 clear a bulk string whose length is a multiple of 64 gets an automatic zero-length packet.
// - bit 0 clear frees transmit pages automatically; set leaves freeing to firmware but still pops the queue.
// - a 16-bit count of start-of-frame tokens goes into every receive header.
// - the receive header holds the 4-bit token code of the packet.
// - the header crc flag is set only for bad crc packets while bad crc acceptance is on.
// - the six-byte header is written at buffer offsets 0 to 5 before payload.
`timescale 1ns/1ps
`default_nettype none
module usb_bulk_transfer_management
  import usb_bulk_pkg::*;
#(
  parameter int LEN_W = 11
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // serial engine side
  input  wire logic              sof_pulse,
  input  wire logic              rx_pkt_valid,
  input  wire rx_info_t          rx_pkt,
  input  wire logic              rx_page_need,
  output logic                   page_req,
  output logic                   rx_ack,
  output logic                   rx_nak,
  output logic                   rx_drop,
  output logic                   hdr_valid,
  output hdr_byte_t              hdr_byte,
  // transmit side
  input  wire logic              tx_pkt_done,
  input  wire logic [LEN_W-1:0]  tx_pkt_len,
  input  wire logic              tx_pkt_last,
  output logic                   zlp_send,
  output logic                   tx_queue_pop,
  output logic                   page_free,
  output logic                   irq
);

  logic [7:0]      ctrl_reg;
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] mask_reg;
  logic [15:0]     frame_count_reg;
  logic [LEN_W-1:0] string_len_reg;
  logic [EV_W-1:0] event_set;

  logic            accept_bad_crc_bulk;
  logic            nak_every_receive_alias;
  logic            manual_zero_length_select;
  logic            manual_page_release;

  assign accept_bad_crc_bulk       = ctrl_reg[BIT_ACCEPT_BAD_CRC];
  assign nak_every_receive_alias   = ctrl_reg[BIT_NAK_ALL];
  assign manual_zero_length_select = ctrl_reg[BIT_MANUAL_ZLP];
  assign manual_page_release       = ctrl_reg[BIT_MANUAL_RELEASE];

  // write channel: address and data taken in either order
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              wr_fire;
  logic              wr_hit;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit  = (aw_addr_reg == CTRL_OFFSET) || (aw_addr_reg == STATUS_OFFSET)
                || (aw_addr_reg == MASK_OFFSET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= '0;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == CTRL_OFFSET) begin
        ctrl_reg <= w_data_reg[7:0] & CTRL_WMASK;
      end
      if (aw_addr_reg == MASK_OFFSET) begin
        mask_reg <= w_data_reg[EV_W-1:0];
      end
    end
  end

  // sticky status: set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == STATUS_OFFSET) begin
      status_reg <= (status_reg & ~w_data_reg[EV_W-1:0]) | event_set;
    end else begin
      status_reg <= status_reg | event_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status_reg | event_set) & mask_reg);
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          CTRL_OFFSET:   s_axi_rdata <= {24'h000000, ctrl_reg};
          STATUS_OFFSET: s_axi_rdata <= {{(32-EV_W){1'b0}}, status_reg};
          MASK_OFFSET:   s_axi_rdata <= {{(32-EV_W){1'b0}}, mask_reg};
          FRAME_OFFSET:  s_axi_rdata <= {16'h0000, frame_count_reg};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_count_reg <= 16'h0000;
    end else if (sof_pulse) begin
      frame_count_reg <= frame_count_reg + 16'h0001;
    end
  end

  // receive decision
  logic        hdr_busy;
  logic        rx_take;
  logic        rx_refuse_crc;
  logic [47:0] header_word;

  assign rx_refuse_crc = rx_pkt.crc_bad && !accept_bad_crc_bulk;
  assign rx_take = rx_pkt_valid && !nak_every_receive_alias && !rx_refuse_crc && !hdr_busy;

  // crc flag only when acceptance on
  assign header_word = {frame_count_reg,
                        8'h00,
                        1'b0, rx_pkt.func_addr,
                        4'h0, rx_pkt.token_code,
                        rx_pkt.crc_bad && accept_bad_crc_bulk, 3'h0, rx_pkt.endpoint};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ack  <= 1'b0;
      rx_nak  <= 1'b0;
      rx_drop <= 1'b0;
    end else begin
      rx_ack  <= rx_take;
      rx_nak  <= rx_pkt_valid && (nak_every_receive_alias || (hdr_busy && !rx_refuse_crc));
      rx_drop <= rx_pkt_valid && !nak_every_receive_alias && rx_refuse_crc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_req <= 1'b0;
    end else begin
      page_req <= rx_page_need && !nak_every_receive_alias;
    end
  end

  rx_header_writer u_hdr (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start     (rx_take),
    .header    (header_word),
    .busy      (hdr_busy),
    .hdr_valid (hdr_valid),
    .hdr_byte  (hdr_byte)
  );

  // transmit side: logical packet length tracking
  logic [LEN_W-1:0] total_len;
  logic             len_multiple;
  logic             zlp_needed;

  assign total_len    = string_len_reg + tx_pkt_len;
  assign len_multiple = (total_len[5:0] == 6'h00);
  assign zlp_needed   = tx_pkt_done && tx_pkt_last && len_multiple && !manual_zero_length_select;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      string_len_reg <= '0;
    end else if (tx_pkt_done) begin
      string_len_reg <= tx_pkt_last ? '0 : total_len;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zlp_send     <= 1'b0;
      tx_queue_pop <= 1'b0;
      page_free    <= 1'b0;
    end else begin
      zlp_send     <= zlp_needed;
      tx_queue_pop <= tx_pkt_done;
      page_free    <= tx_pkt_done && !manual_page_release;
    end
  end

  always_comb begin
    event_set = '0;
    event_set[EV_RX_DONE]  = rx_take;
    event_set[EV_RX_DROP]  = rx_pkt_valid && !rx_take;
    event_set[EV_ZLP_SENT] = zlp_needed;
    event_set[EV_PAGE_REL] = tx_pkt_done && !manual_page_release;
  end

endmodule
`default_nettype wire

// ---- tb/usb_bulk_sva.sv ----
/*
  checker: receive outcome, header bytes, transmit pulses.
  assumes binding to the top module and no sof pulse inside a header.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_bulk_sva
  import usb_bulk_pkg::*;
(
  input wire logic      aclk,
  input wire logic      aresetn,
  input wire logic      sof_pulse,
  input wire logic      rx_pkt_valid,
  input wire rx_info_t  rx_pkt,
  input wire logic      rx_ack,
  input wire logic      rx_nak,
  input wire logic      rx_drop,
  input wire logic      hdr_valid,
  input wire hdr_byte_t hdr_byte,
  input wire logic      tx_pkt_done,
  input wire logic      tx_pkt_last,
  input wire logic      zlp_send,
  input wire logic      tx_queue_pop
);
  logic [15:0] sof_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) sof_cnt <= 16'h0000;
    else if (sof_pulse) sof_cnt <= sof_cnt + 16'h0001;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence taken_s;
    rx_pkt_valid ##1 rx_ack;
  endsequence
  one_outcome_a: assert property (rx_pkt_valid |=> $onehot({rx_ack, rx_nak, rx_drop}))
    else $error("receive outcome not single");
  outcome_cause_a: assert property ((rx_ack || rx_nak || rx_drop) |-> $past(rx_pkt_valid))
    else $error("outcome without packet");
  hdr_start_a: assert property (rx_ack |=> hdr_valid && hdr_byte.offset == HDR_FIRST)
    else $error("header not at offset zero");
  hdr_order_a: assert property (hdr_valid && hdr_byte.offset != HDR_LAST
    |=> hdr_valid && hdr_byte.offset == $past(hdr_byte.offset) + 3'h1) else $error("header bytes out of order");
  token_field_a: assert property (taken_s ##2 1'b1 |-> hdr_byte.data == {4'h0, $past(rx_pkt.token_code, 3)})
    else $error("token code byte wrong");
  crc_flag_a: assert property (taken_s ##1 1'b1 |-> hdr_byte.data[7] == $past(rx_pkt.crc_bad, 2))
    else $error("crc flag wrong");
  frame_field_a: assert property (hdr_valid && hdr_byte.offset[2]
    |-> hdr_byte.data == (hdr_byte.offset[0] ? sof_cnt[15:8] : sof_cnt[7:0])) else $error("frame count wrong");
  tx_pop_a: assert property (tx_pkt_done |=> tx_queue_pop)
    else $error("queue not popped");
  zlp_cause_a: assert property (zlp_send |-> $past(tx_pkt_done) && $past(tx_pkt_last))
    else $error("zero-length packet without string end");
endmodule
bind usb_bulk_transfer_management usb_bulk_sva u_sva (.*);
`default_nettype wire

// ---- tb/usb_engine_model.sv ----
/*
  far-side model of the usb serial engine: frame, receive, transmit events.
  assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_engine_model
  import usb_bulk_pkg::*;
(
  input  wire logic   aclk,
  output logic        sof_pulse,
  output logic        rx_pkt_valid,
  output rx_info_t    rx_pkt,
  output logic        rx_page_need,
  output logic        tx_pkt_done,
  output logic [10:0] tx_pkt_len,
  output logic        tx_pkt_last
);
  initial begin
    {sof_pulse, rx_pkt_valid, rx_page_need, tx_pkt_done, tx_pkt_last} = 5'h00;
    rx_pkt = '0;
    tx_pkt_len = 11'h000;
  end
  // released lines flip so a stale value never looks valid
  task automatic rx(input logic [3:0] tok, input logic bad);
    @(posedge aclk);
    rx_pkt_valid <= 1'b1;
    rx_pkt <= '{4'h2, tok, 7'h05, bad};
    @(posedge aclk);
    rx_pkt_valid <= 1'b0;
    rx_pkt <= ~rx_pkt;
    repeat (8) @(posedge aclk);
  endtask
  task automatic sof();
    @(posedge aclk);
    sof_pulse <= 1'b1;
    @(posedge aclk);
    sof_pulse <= 1'b0;
  endtask
  task automatic tx(input logic [10:0] len, input logic last);
    @(posedge aclk);
    tx_pkt_done <= 1'b1;
    tx_pkt_len <= len;
    tx_pkt_last <= last;
    @(posedge aclk);
    tx_pkt_done <= 1'b0;
    tx_pkt_len <= ~len;
    tx_pkt_last <= ~last;
    repeat (2) @(posedge aclk);
  endtask
  task automatic need(input logic v);
    @(posedge aclk);
    rx_page_need <= v;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_usb_bulk_transfer_management.sv ----
/*
  bench: axi4-lite register tasks and engine event sequences.
  assumes the engine model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_usb_bulk_transfer_management
  import usb_bulk_pkg::*;
;
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [1:0]        bresp_seen = 2'h0;
  logic              sof_pulse, rx_pkt_valid, rx_page_need, page_req, rx_ack, rx_nak, rx_drop, hdr_valid;
  logic              tx_pkt_done, tx_pkt_last, zlp_send, tx_queue_pop, page_free, irq;
  logic [10:0]       tx_pkt_len;
  rx_info_t          rx_pkt;
  hdr_byte_t         hdr_byte;
  logic [7:0]        cnt [6] = '{default: 8'h00};
  int                mismatches = 0, comparisons = 0;
  always #25 aclk = ~aclk;
  // counting waits for reset so unknowns before it cannot poison totals
  always @(posedge aclk) begin
    if (aresetn) begin
      cnt[0] <= cnt[0] + {7'h00, rx_ack};
      cnt[1] <= cnt[1] + {7'h00, rx_nak};
      cnt[2] <= cnt[2] + {7'h00, rx_drop};
      cnt[3] <= cnt[3] + {7'h00, zlp_send};
      cnt[4] <= cnt[4] + {7'h00, tx_queue_pop};
      cnt[5] <= cnt[5] + {7'h00, page_free};
    end
  end
  usb_bulk_transfer_management u_dut (.*);
  usb_engine_model u_eng (.*);
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    $display("MISMATCH at %0t: bus wait ran out", $time);
    finish_test();
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 100) give_up();
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 100) give_up();
    chk({s_axi_rresp, s_axi_rdata}, {r, d});
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFFSET, 32'h00000000, RESP_OKAY);
    wr(CTRL_OFFSET, 32'hFFFFFFFF);
    rd(CTRL_OFFSET, 32'h0000000F, RESP_OKAY);
    rd(17'h1FC00, 32'h00000000, RESP_SLVERR);
    wr(17'h1FC00, 32'h00000000);
    chk(bresp_seen, RESP_SLVERR);
    // low byte strobe off: write answered but ignored
    s_axi_wstrb <= 4'hE;
    wr(CTRL_OFFSET, 32'h00000000);
    chk(bresp_seen, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(CTRL_OFFSET, 32'h0000000F, RESP_OKAY);
    $display("register test done");
    wr(CTRL_OFFSET, 32'h00000000);
    repeat (3) u_eng.sof();
    rd(FRAME_OFFSET, 32'h00000003, RESP_OKAY);
    u_eng.rx(4'h1, 1'b0);
    u_eng.rx(4'h9, 1'b1);
    wr(CTRL_OFFSET, 32'h00000008);
    u_eng.rx(4'hD, 1'b1);
    // nak-all goes up before the page bits are inspected
    wr(CTRL_OFFSET, 32'h0000000C);
    u_eng.need(1'b1);
    u_eng.rx(4'h3, 1'b0);
    chk(page_req, 1'b0);
    chk({cnt[0], cnt[1], cnt[2]}, 24'h020101);
    wr(CTRL_OFFSET, 32'h00000000);
    // page request follows the cleared bit one cycle later
    repeat (2) @(posedge aclk);
    chk(page_req, 1'b1);
    u_eng.need(1'b0);
    $display("receive test done");
    u_eng.tx(11'h040, 1'b0);
    u_eng.tx(11'h040, 1'b1);
    u_eng.tx(11'h03F, 1'b1);
    u_eng.tx(11'h000, 1'b1);
    // release mode changes only while the queue is idle
    wr(CTRL_OFFSET, 32'h00000003);
    u_eng.tx(11'h040, 1'b1);
    // firmware queues its own zero-length packet
    u_eng.tx(11'h000, 1'b1);
    chk({cnt[3], cnt[4], cnt[5]}, 24'h020604);
    $display("transmit test done");
    rd(STATUS_OFFSET, 32'h0000000F, RESP_OKAY);
    chk(irq, 1'b0);
    wr(MASK_OFFSET, 32'h00000001);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    wr(STATUS_OFFSET, 32'h00000001);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    rd(STATUS_OFFSET, 32'h0000000E, RESP_OKAY);
    u_eng.rx(4'h5, 1'b0);
    chk(irq, 1'b1);
    wr(MASK_OFFSET, 32'h00000000);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    $display("interrupt test done");
    finish_test();
  end
endmodule
`default_nettype wire
